// file: inc/fgob_consts.svh
`ifndef FGOB_CONSTS_SVH
`define FGOB_CONSTS_SVH
// Coefficient width codes
`define FGOB_CW_4        2'h0
`define FGOB_CW_8        2'h1
`define FGOB_CW_12       2'h2
`define FGOB_CW_16       2'h3
// Minimum spacing between strobe samplings, cycles
`define FGOB_SPACE_4     4'h2
`define FGOB_SPACE_8     4'h4
`define FGOB_SPACE_12    4'h6
`define FGOB_SPACE_16    4'h8
// Delay from accepted strobe to new output sequence, cycles
`define FGOB_DELAY_4     4'h6
`define FGOB_DELAY_8     4'h8
`define FGOB_DELAY_12    4'ha
`define FGOB_DELAY_16    4'hc
// Accepted strobes remembered, one per cycle of the longest delay
`define FGOB_PIPE_DEPTH  12
// Normal mode low word duration, cycles
`define FGOB_LOW_8       4'h1
`define FGOB_LOW_12      4'h2
`define FGOB_LOW_16      4'h3
// Fast mode high word extra periods over 4 bit case
`define FGOB_FAST_XTRA_4  4'h0
`define FGOB_FAST_XTRA_8  4'h2
`define FGOB_FAST_XTRA_12 4'h4
`define FGOB_FAST_XTRA_16 4'h6
// Fast mode base high word duration, cycles
`define FGOB_FAST_BASE   4'h1
// Swap request bit positions in the control words
`define FGOB_MAIN_SWAP_BIT 0
`define FGOB_SEC_SWAP_BIT  2
// Master strobe drive delay after data write, cycles
`define FGOB_MASTER_DLY  2'h1
`define FGOB_CNT_ONE     4'h1
`define FGOB_CNT_ZERO    4'h0
`endif

// file: inc/fgob_pkg.sv
package fgob_pkg;
  typedef enum logic [1:0] {FGOB_OUT_IDLE, FGOB_OUT_LOW, FGOB_OUT_HIGH} fgob_out_t;
  typedef logic [3:0] fgob_cnt_t;
endpackage

// file: inc/fgob_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fgob_sync_if;
  logic async_in;
  logic sync_out;
  modport src (output async_in);
  modport snk (input async_in, output sync_out);
endinterface
`default_nettype wire

// file: src/fgob_sync.sv
`timescale 1ns/1ns
`default_nettype none
module fgob_sync
(
  input  wire logic   i_ref_clk,
  input  wire logic   i_reset,
  fgob_sync_if.snk    sif
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= sif.async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sif.sync_out = sync_reg;
endmodule
`default_nettype wire

// file: src/fgob_seq.sv
`timescale 1ns/1ns
`default_nettype none
`include "fgob_consts.svh"
module fgob_seq
  import fgob_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_coef_width,
  input  wire logic       i_fast_mode,
  input  wire logic       i_master_mode,
  input  wire logic       i_strobe_pin,
  input  wire logic       i_data_write,
  input  wire logic       i_main_ctrl_write,
  input  wire logic [7:0] i_main_ctrl_data,
  input  wire logic       i_sec_ctrl_write,
  input  wire logic [7:0] i_sec_ctrl_data,
  output logic            o_strobe_out,
  output logic            o_strobe_oe,
  output logic            o_sample_point,
  output logic            o_input_taken,
  output logic            o_low_result_word,
  output logic            o_high_result_word,
  output logic            o_output_word_strobe,
  output logic            o_bank_select,
  output logic            o_busy
);
  ////////////////////////////////////////////////////////////////////////////
  // Strobe input synchroniser
  fgob_sync_if sif ();
  logic strobe_sync;

  assign sif.async_in = i_strobe_pin;
  assign strobe_sync  = sif.sync_out;

  fgob_sync u_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .sif       (sif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Static per-width figures
  fgob_cnt_t space_sel;
  fgob_cnt_t delay_sel;
  fgob_cnt_t low_sel;
  fgob_cnt_t fast_sel;

  assign space_sel = (i_coef_width == `FGOB_CW_4)  ? `FGOB_SPACE_4  :
                     (i_coef_width == `FGOB_CW_8)  ? `FGOB_SPACE_8  :
                     (i_coef_width == `FGOB_CW_12) ? `FGOB_SPACE_12 : `FGOB_SPACE_16;
  assign delay_sel = (i_coef_width == `FGOB_CW_4)  ? `FGOB_DELAY_4  :
                     (i_coef_width == `FGOB_CW_8)  ? `FGOB_DELAY_8  :
                     (i_coef_width == `FGOB_CW_12) ? `FGOB_DELAY_12 : `FGOB_DELAY_16;
  assign low_sel   = (i_coef_width == `FGOB_CW_12) ? `FGOB_LOW_12 :
                     (i_coef_width == `FGOB_CW_16) ? `FGOB_LOW_16 : `FGOB_LOW_8;
  assign fast_sel  = (i_coef_width == `FGOB_CW_4)  ? `FGOB_FAST_XTRA_4  :
                     (i_coef_width == `FGOB_CW_8)  ? `FGOB_FAST_XTRA_8  :
                     (i_coef_width == `FGOB_CW_12) ? `FGOB_FAST_XTRA_12 : `FGOB_FAST_XTRA_16;

  ////////////////////////////////////////////////////////////////////////////
  // Master strobe generation
  logic [1:0] mstr_cnt_reg;
  logic       mstr_reg;
  logic       strobe_level;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      mstr_cnt_reg <= 2'h0;
      mstr_reg     <= 1'b0;
    end
    else if (i_master_mode && i_data_write)
    begin
      mstr_cnt_reg <= `FGOB_MASTER_DLY;
      mstr_reg     <= 1'b0;
    end
    else if (mstr_cnt_reg != 2'h0)
    begin
      mstr_cnt_reg <= mstr_cnt_reg - 2'h1;
      mstr_reg     <= (mstr_cnt_reg == 2'h1);
    end
    else if (o_input_taken)
      mstr_reg <= 1'b0;
  end

  assign o_strobe_out = mstr_reg;
  assign o_strobe_oe  = i_master_mode;
  assign strobe_level = i_master_mode ? mstr_reg : strobe_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Sampling spacing
  fgob_cnt_t space_reg;
  logic      sample_now;

  assign sample_now     = (space_reg == `FGOB_CNT_ZERO);
  assign o_sample_point = sample_now;
  assign o_input_taken  = sample_now && strobe_level;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      space_reg <= `FGOB_CNT_ZERO;
    else if (o_input_taken)
      space_reg <= space_sel - `FGOB_CNT_ONE;
    else if (!sample_now)
      space_reg <= space_reg - `FGOB_CNT_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output sequence delay and word durations
  logic [`FGOB_PIPE_DEPTH-1:0] take_pipe_reg;
  logic      seq_start;
  fgob_out_t out_state_reg;
  fgob_out_t out_state_next;
  fgob_cnt_t word_cnt_reg;
  fgob_cnt_t word_cnt_next;
  logic      word_done;

  // One bit per accepted strobe: inputs closer than the delay each start a sequence
  assign seq_start = take_pipe_reg[delay_sel - `FGOB_CNT_ONE];
  assign word_done = (word_cnt_reg == `FGOB_CNT_ONE);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      take_pipe_reg <= '0;
    else
      take_pipe_reg <= {take_pipe_reg[`FGOB_PIPE_DEPTH-2:0], o_input_taken};
  end

  // High word holds until the next sequence; idle cycles thus lengthen it
  always_comb
  begin
    out_state_next = out_state_reg;
    word_cnt_next  = word_cnt_reg;
    if (seq_start)
    begin
      if (i_fast_mode)
      begin
        out_state_next = FGOB_OUT_HIGH;
        word_cnt_next  = `FGOB_FAST_BASE + fast_sel;
      end
      else
      begin
        out_state_next = FGOB_OUT_LOW;
        word_cnt_next  = low_sel;
      end
    end
    else
    begin
      case (out_state_reg)
        FGOB_OUT_LOW:
        begin
          if (word_done)
          begin
            out_state_next = FGOB_OUT_HIGH;
            word_cnt_next  = low_sel;
          end
          else
            word_cnt_next = word_cnt_reg - `FGOB_CNT_ONE;
        end
        FGOB_OUT_HIGH:
        begin
          if (!word_done && word_cnt_reg != `FGOB_CNT_ZERO)
            word_cnt_next = word_cnt_reg - `FGOB_CNT_ONE;
        end
        FGOB_OUT_IDLE:
          word_cnt_next = `FGOB_CNT_ZERO;
        default:
          out_state_next = FGOB_OUT_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      out_state_reg        <= FGOB_OUT_IDLE;
      word_cnt_reg         <= `FGOB_CNT_ZERO;
      o_low_result_word    <= 1'b0;
      o_high_result_word   <= 1'b0;
      o_output_word_strobe <= 1'b0;
    end
    else
    begin
      out_state_reg        <= out_state_next;
      word_cnt_reg         <= word_cnt_next;
      o_low_result_word    <= (out_state_next == FGOB_OUT_LOW);
      o_high_result_word   <= (out_state_next == FGOB_OUT_HIGH);
      o_output_word_strobe <= (out_state_next == FGOB_OUT_HIGH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank swap
  logic swap_req;
  logic pend_reg;
  logic bank_reg;

  assign swap_req = (i_main_ctrl_write && i_main_ctrl_data[`FGOB_MAIN_SWAP_BIT]) ||
                    (i_sec_ctrl_write && i_sec_ctrl_data[`FGOB_SEC_SWAP_BIT]);

  // A request landing on the sampling edge swaps at once: busy never shows
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      pend_reg <= 1'b0;
      bank_reg <= 1'b0;
    end
    else if (sample_now && (pend_reg || swap_req))
    begin
      pend_reg <= 1'b0;
      bank_reg <= !bank_reg;
    end
    else if (swap_req)
      pend_reg <= 1'b1;
  end

  assign o_bank_select = bank_reg;
  assign o_busy        = pend_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence taken_s;
    o_input_taken;
  endsequence

  sequence gap_s;
    !o_sample_point;
  endsequence

  property spacing_p;
    @(posedge i_ref_clk) disable iff (i_reset)
      (taken_s and (i_coef_width == `FGOB_CW_8)) |=> gap_s [*3] ##1 o_sample_point;
  endproperty

  min_spacing_a: assert property (spacing_p)
    else $error("strobe spacing wrong");

  sample_each_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_sample_point && !o_input_taken) |=> o_sample_point)
    else $error("sampling not continued");

  out_delay_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_input_taken && i_coef_width == `FGOB_CW_8 && !i_fast_mode) |=> ##8 o_low_result_word)
    else $error("output delay wrong");

  low_len_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      ($rose(o_low_result_word) && i_coef_width == `FGOB_CW_12) |=> o_low_result_word ##1 !o_low_result_word)
    else $error("low word duration wrong");

  high_after_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      $fell(o_low_result_word) |-> o_high_result_word)
    else $error("high word missing");

  fast_len_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      ($rose(o_high_result_word) && i_fast_mode && i_coef_width == `FGOB_CW_16 &&
       !o_low_result_word) |-> o_high_result_word [*7])
    else $error("fast high word too short");

  master_go_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (i_master_mode && i_data_write) |-> ##[1:2] o_strobe_out)
    else $error("master strobe late");

  swap_pend_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (swap_req && !o_sample_point) |=> o_busy)
    else $error("swap not pending");

  swap_at_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_busy && o_sample_point) |=> (o_bank_select != $past(o_bank_select)) && !o_busy)
    else $error("swap not taken");
endmodule
`default_nettype wire

// file: tb/fgob_partner.sv
`timescale 1ns/1ns
`default_nettype none
module fgob_partner
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_reset,
  input  wire logic  i_bank,
  input  wire logic  i_strobe,
  output logic       o_pin,
  output logic       o_data_wr,
  output logic       o_main_wr,
  output logic [7:0] o_main_data,
  output logic       o_sec_wr,
  output logic [7:0] o_sec_data
);
  logic wait_swap;
  logic bank_seen;
  int   quiet;
  initial
  begin
    {o_pin, o_data_wr, o_main_wr, o_sec_wr, wait_swap, bank_seen} = '0;
    {o_main_data, o_sec_data} = '0;
    quiet = 0;
  end
  // Host and strobe source; changes land 2 ns after the edge
  always @(posedge i_ref_clk)
  begin
    #2;
    o_pin = ($urandom % 3) == 0;
    o_data_wr = 1'b0;
    if (i_strobe)
      quiet = 4;
    else if (quiet > 0)
      quiet--;
    if (quiet == 0 && ($urandom % 8) == 0)
    begin
      o_data_wr = 1'b1;
      quiet = 4;
    end
    if (i_reset || i_bank !== bank_seen)
      wait_swap = 1'b0;
    // Swap points tracked; no further swap request is made while one is awaited
    bank_seen = i_bank;
    o_main_wr = !i_reset && ($urandom % 6) == 0;
    o_sec_wr = !i_reset && ($urandom % 6) == 0;
    o_main_data = 8'($urandom);
    o_sec_data = 8'($urandom);
    if (wait_swap)
    begin
      o_main_data[0] = 1'b0;
      o_sec_data[2] = 1'b0;
    end
    else if ((o_main_wr && o_main_data[0]) || (o_sec_wr && o_sec_data[2]))
      wait_swap = 1'b1;
  end
endmodule
`default_nettype wire

// file: tb/tb_filter_go_output_bankswap_seq.sv
`timescale 1ns/1ns
`default_nettype none
module tb_filter_go_output_bankswap_seq;
  import fgob_pkg::*;
  logic       i_ref_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic [1:0] i_coef_width = 2'h0;
  logic       i_fast_mode = 1'b0;
  logic       i_master_mode = 1'b0;
  logic       i_strobe_pin, i_data_write, i_main_ctrl_write, i_sec_ctrl_write;
  logic [7:0] i_main_ctrl_data, i_sec_ctrl_data;
  logic       o_strobe_out, o_strobe_oe, o_sample_point, o_input_taken;
  logic       o_low_result_word, o_high_result_word, o_output_word_strobe;
  logic       o_bank_select, o_busy;
  int         errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         last_take, wq, lw_n, hw_n, m, w;
  logic       h0, h1, lvl, sp, pend, bank, wr, lw_p, hw_p;
  int         sq[$];
  always #20 i_ref_clk = ~i_ref_clk;
  fgob_seq fgob_seq_inst (.*);
  fgob_partner fgob_partner_inst
  (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_bank      (o_bank_select),
    .i_strobe    (o_strobe_out),
    .o_pin       (i_strobe_pin),
    .o_data_wr   (i_data_write),
    .o_main_wr   (i_main_ctrl_write),
    .o_main_data (i_main_ctrl_data),
    .o_sec_wr    (i_sec_ctrl_write),
    .o_sec_data  (i_sec_ctrl_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reference model, reads the cycle that just ended at each edge
  always @(posedge i_ref_clk)
  begin
    cyc++;
    w = int'(i_coef_width);
    if (cyc > 4500)
    begin
      errors++;
      close_out();
    end
    else if (i_reset)
    begin
      last_take = -100;
      wq = -9;
      {h0, h1, pend, bank, lw_p, hw_p} = '0;
      lw_n = 0;
      hw_n = 0;
      sq.delete();
    end
    else
    begin
      lvl = i_master_mode ? o_strobe_out : h1;
      sp = (cyc - last_take) >= 2 * w + 2;
      check(16'(o_sample_point), 16'(sp));
      check(16'(o_input_taken), 16'(sp && lvl));
      check(16'(o_strobe_oe), 16'(i_master_mode));
      if (!i_master_mode || wq == cyc - 2)
        check(16'(o_strobe_out), 16'(i_master_mode));
      if (i_data_write)
        wq = cyc;
      if (sp && lvl)
      begin
        last_take = cyc;
        sq.push_back(cyc + 2 * w + 7);
      end
      if (i_fast_mode ? (o_high_result_word && !hw_p) : (o_low_result_word && !lw_p))
        check(16'(cyc), 16'((sq.size() > 0) ? sq.pop_front() : -1));
      if (!o_low_result_word && lw_p)
        check(16'(lw_n), 16'((w == 0) ? 1 : w));
      if (!o_high_result_word && hw_p)
      begin
        check(16'(hw_n >= (i_fast_mode ? 1 + 2 * w : ((w == 0) ? 1 : w))), 16'h1);
        if (!i_fast_mode)
          check(16'(o_low_result_word), 16'h1);
      end
      check(16'(o_output_word_strobe), 16'(o_high_result_word));
      lw_n = o_low_result_word ? lw_n + 1 : 0;
      hw_n = o_high_result_word ? hw_n + 1 : 0;
      lw_p = o_low_result_word;
      hw_p = o_high_result_word;
      wr = (i_main_ctrl_write && i_main_ctrl_data[0]) ||
           (i_sec_ctrl_write && i_sec_ctrl_data[2]);
      check(16'(o_bank_select), 16'(bank));
      check(16'(o_busy), 16'(pend));
      if (sp && (pend || wr))
      begin
        bank = !bank;
        pend = 1'b0;
      end
      else if (wr)
        pend = 1'b1;
      h1 = h0;
      h0 = i_strobe_pin;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Every width in both output modes, then every width as strobe master
  initial
  begin
    void'($urandom(32'h27f2));
    for (m = 0; m < 12; m++)
    begin
      i_reset = 1'b1;
      i_coef_width = m[1:0];
      i_fast_mode = m[2];
      i_master_mode = m[3];
      repeat (20) @(posedge i_ref_clk);
      #2 i_reset = 1'b0;
      repeat (300) @(posedge i_ref_clk);
      #2;
    end
    close_out();
  end
endmodule
`default_nettype wire
